/* hdl/logic_slice_lut_carry_ram.v */
`timescale 1ns/1ps
`include "logic_slice_defines.vh"
module logic_slice_lut_carry_ram (
	input wire i_mclk,
	input wire i_rst,
	input wire [1:0] i_mode,
	input wire [2:0] i_ripple_func,
	input wire i_addsub_ctrl,
	input wire [95:0] i_table_init,
	input wire [23:0] i_lut_in,
	input wire [5:0] i_multi_purpose_in,
	input wire [2:0] i_clk_en,
	input wire [2:0] i_local_set_reset,
	input wire [2:0] i_set_reset_level,
	input wire [1:0] i_wide_cascade_in,
	input wire i_carry_chain_in,
	output wire [2:0] o_table0_comb_out,
	output wire [2:0] o_table1_comb_out,
	output wire [2:0] o_reg0_out,
	output wire [2:0] o_reg1_out,
	output wire [2:0] o_five_input_mux_out,
	output wire [2:0] o_wide_mux_out,
	output wire o_carry_chain_out,
	output wire [2:0] o_cmp_ge,
	output wire [2:0] o_cmp_ne,
	output wire [2:0] o_cmp_le
);
	// table storage: tables 0..3 double as the four RAM bit planes
	reg [15:0] table_r [0:5];

	wire is_ripple;
	wire is_ram;
	wire is_counter;
	wire is_sub;
	wire count_down;
	wire preload_fn;
	wire clear_fn;

	wire ram_write_clock;
	wire ram_write_enable;
	wire [3:0] ram_write_address;
	wire [3:0] ram_write_data;

	wire [2:0] lut0_w;
	wire [2:0] lut1_w;
	wire [2:0] tab0_out_w;
	wire [2:0] tab1_out_w;
	wire [2:0] mux5_w;
	wire [2:0] wide_w;
	wire [5:0] sum_w;
	wire [5:0] q_w;
	wire [3:0] carry_w;

	integer k;

	assign is_ripple = (i_mode == `MODE_RIPPLE);
	assign is_ram = (i_mode == `MODE_RAM);

	assign is_counter = (i_ripple_func == `FN_UP_COUNT) ||
		(i_ripple_func == `FN_DOWN_COUNT) ||
		(i_ripple_func == `FN_UPDN_CLEAR) ||
		(i_ripple_func == `FN_UPDN_LOAD);
	// dynamic control high selects add, low selects subtract
	assign is_sub = (i_ripple_func == `FN_SUB) ||
		((i_ripple_func == `FN_ADDSUB) && !i_addsub_ctrl);
	assign count_down = (i_ripple_func == `FN_DOWN_COUNT) ||
		(((i_ripple_func == `FN_UPDN_CLEAR) || (i_ripple_func == `FN_UPDN_LOAD)) &&
		!i_addsub_ctrl);
	assign preload_fn = (i_ripple_func == `FN_UPDN_LOAD);
	assign clear_fn = (i_ripple_func == `FN_UPDN_CLEAR);

	// slice 2 is the memory controller when the group runs as RAM
	assign ram_write_clock = i_mclk;
	assign ram_write_enable = is_ram && i_local_set_reset[2];
	assign ram_write_address = i_lut_in[2*`SLICE_IN_BITS +: 4];
	assign ram_write_data = i_lut_in[2*`SLICE_IN_BITS + `IN_TABLE1_LSB +: 4];

	// tables are loaded from the init vector during reset, then only RAM writes change them
	always @(posedge ram_write_clock) begin
		if (i_rst) begin
			for (k = 0; k < `TABLE_COUNT; k = k + 1) begin
				table_r[k] <= i_table_init[k*`TABLE_BITS +: `TABLE_BITS];
			end
		end else if (ram_write_enable) begin
			// planes 0,1 sit in slice 0 and planes 2,3 in slice 1
			for (k = 0; k < `RAM_TABLE_COUNT; k = k + 1) begin
				table_r[k][ram_write_address] <= ram_write_data[k];
			end
		end
	end

	assign carry_w[0] = i_carry_chain_in;
	assign o_carry_chain_out = carry_w[3];

	genvar g;
	generate
		for (g = 0; g < `SLICE_COUNT; g = g + 1) begin : slice
			wire [3:0] in0;
			wire [3:0] in1;
			wire [1:0] op_a;
			wire [1:0] op_b;
			wire [1:0] raw_b;
			wire [1:0] reg_d;
			wire mux_sel0;
			wire mux_sel1;
			wire load_now;
			wire sr_eff;

			assign in0 = i_lut_in[g*`SLICE_IN_BITS +: 4];
			assign in1 = i_lut_in[g*`SLICE_IN_BITS + `IN_TABLE1_LSB +: 4];
			assign mux_sel0 = i_multi_purpose_in[2*g];
			assign mux_sel1 = i_multi_purpose_in[2*g+1];

			// asynchronous read of the addressed entry
			assign lut0_w[g] = table_r[2*g][in0];
			assign lut1_w[g] = table_r[2*g+1][in1];

			// outside the counters, operand A is table input A of each table, B is input B
			assign raw_b = {in1[`IN_CARRY_B], in0[`IN_CARRY_B]};
			assign op_a = is_counter ? q_w[2*g +: 2] : {in1[`IN_CARRY_A], in0[`IN_CARRY_A]};
			assign op_b = is_counter ? {2{count_down}} : (raw_b ^ {2{is_sub}});

			carry_pair u_carry (
				.i_a(op_a),
				.i_b(op_b),
				.i_cin(carry_w[g]),
				.o_sum(sum_w[2*g +: 2]),
				.o_cout(carry_w[g+1])
			);

			assign tab0_out_w[g] = is_ripple ? sum_w[2*g] : lut0_w[g];
			assign tab1_out_w[g] = is_ripple ? sum_w[2*g+1] : lut1_w[g];

			// fifth input picks between the two four-input halves
			assign mux5_w[g] = mux_sel0 ? lut1_w[g] : lut0_w[g];

			// preload takes the D inputs when the C input of table 0 strobes
			assign load_now = is_ripple && preload_fn && in0[`IN_LOAD_STROBE];
			assign reg_d = load_now ? {in1[`IN_LOAD_DATA], in0[`IN_LOAD_DATA]} :
				{tab1_out_w[g], tab0_out_w[g]};

			// in RAM mode slice 2's set/reset is the write enable, not a register control
			if (g == 2) begin : ctl
				assign sr_eff = i_local_set_reset[g] && !is_ram;
			end else begin : plain
				assign sr_eff = i_local_set_reset[g];
			end

			// the clear acts at the next clock edge; a true asynchronous path is not modelled
			slice_ff_pair u_regs (
				.i_mclk(i_mclk),
				.i_rst(i_rst),
				.i_clk_en(i_clk_en[g] || load_now),
				.i_set_reset(sr_eff),
				.i_sr_level(i_set_reset_level[g] && !(is_ripple && clear_fn)),
				.i_d(reg_d),
				.o_q(q_w[2*g +: 2])
			);

			// comparator on the two-bit operands of this slice
			assign o_cmp_ge[g] = ({in1[`IN_CARRY_A], in0[`IN_CARRY_A]} >= raw_b) && is_ripple;
			assign o_cmp_ne[g] = ({in1[`IN_CARRY_A], in0[`IN_CARRY_A]} != raw_b) && is_ripple;
			assign o_cmp_le[g] = ({in1[`IN_CARRY_A], in0[`IN_CARRY_A]} <= raw_b) && is_ripple;

			assign o_table0_comb_out[g] = tab0_out_w[g];
			assign o_table1_comb_out[g] = tab1_out_w[g];
			assign o_reg0_out[g] = q_w[2*g];
			assign o_reg1_out[g] = q_w[2*g+1];
			assign o_five_input_mux_out[g] = mux5_w[g];
		end
	endgenerate

	// wide functions: slice 1 forms six inputs, slice 2 seven, slice 0 eight.
	// seven and eight need a neighbouring group's wide outputs, so eight spans more
	// than four slices.
	assign wide_w[1] = i_multi_purpose_in[3] ? mux5_w[1] : mux5_w[0];
	assign wide_w[2] = i_multi_purpose_in[5] ? i_wide_cascade_in[0] : wide_w[1];
	assign wide_w[0] = i_multi_purpose_in[1] ? i_wide_cascade_in[1] : wide_w[2];
	assign o_wide_mux_out = wide_w;

	// the whole 16x4 memory, single or pseudo dual port, lives in these three slices:
	// read addresses are the table inputs of slices 0 and 1, the write port is slice 2
endmodule

/* hdl/logic_slice_defines.vh */
`ifndef LOGIC_SLICE_DEFINES_VH
`define LOGIC_SLICE_DEFINES_VH

// operating modes of a slice group
`define MODE_LOGIC 2'h0
`define MODE_RIPPLE 2'h1
`define MODE_RAM 2'h2
`define MODE_ROM 2'h3

// ripple-mode functions
`define FN_ADD 3'h0
`define FN_SUB 3'h1
`define FN_ADDSUB 3'h2
`define FN_UP_COUNT 3'h3
`define FN_DOWN_COUNT 3'h4
`define FN_UPDN_CLEAR 3'h5
`define FN_UPDN_LOAD 3'h6

// structure
`define TABLE_BITS 16
`define TABLE_COUNT 6
`define RAM_TABLE_COUNT 4
`define SLICE_COUNT 3
`define SLICE_IN_BITS 8

// field positions inside one slice's 8 lookup inputs
`define IN_TABLE1_LSB 4
`define IN_CARRY_A 0
`define IN_CARRY_B 1
`define IN_LOAD_STROBE 2
`define IN_LOAD_DATA 3

// register reset value
`define REG_RESET 2'h0

`endif

/* hdl/carry_pair.v */
`timescale 1ns/1ps
// two-bit ripple cell built from generate and propagate terms
module carry_pair (
	input wire [1:0] i_a,
	input wire [1:0] i_b,
	input wire i_cin,
	output wire [1:0] o_sum,
	output wire o_cout
);
	wire [1:0] gen;
	wire [1:0] prop;
	wire mid_carry;

	assign gen = i_a & i_b;
	assign prop = i_a ^ i_b;
	assign mid_carry = gen[0] | (prop[0] & i_cin);
	assign o_cout = gen[1] | (prop[1] & mid_carry);
	assign o_sum = prop ^ {mid_carry, i_cin};
endmodule

/* hdl/slice_ff_pair.v */
`timescale 1ns/1ps
`include "logic_slice_defines.vh"
// the two output registers of one slice
module slice_ff_pair (
	input wire i_mclk,
	input wire i_rst,
	input wire i_clk_en,
	input wire i_set_reset,
	input wire i_sr_level,
	input wire [1:0] i_d,
	output reg [1:0] o_q
);
	// local set/reset overrides clock enable, so a disabled register can still be cleared
	always @(posedge i_mclk) begin
		if (i_rst) begin
			o_q <= `REG_RESET;
		end else if (i_set_reset) begin
			o_q <= {2{i_sr_level}};
		end else if (i_clk_en) begin
			o_q <= i_d;
		end
	end
endmodule

/* bench/far_fabric.sv */
`timescale 1ns/1ps
module far_fabric (
	input wire i_mclk,
	input wire i_carry_req,
	input wire [1:0] i_casc_req,
	output reg o_carry,
	output reg [1:0] o_casc
);
	// a registered neighbour answers one cycle late, never in the same cycle
	initial {o_carry, o_casc} = 3'h0;
	always @(posedge i_mclk) begin
		o_carry <= i_carry_req;
		o_casc <= i_casc_req;
	end
endmodule

/* bench/logic_slice_props.sv */
`timescale 1ns/1ps
module logic_slice_props (
	input wire i_mclk,
	input wire i_rst,
	input wire [1:0] i_mode,
	input wire [2:0] i_ripple_func,
	input wire [23:0] i_lut_in,
	input wire [5:0] i_multi_purpose_in,
	input wire [2:0] i_clk_en,
	input wire [2:0] i_local_set_reset,
	input wire [2:0] i_set_reset_level,
	input wire [2:0] o_table0_comb_out,
	input wire [2:0] o_table1_comb_out,
	input wire [2:0] o_reg0_out,
	input wire [2:0] o_reg1_out,
	input wire [2:0] o_five_input_mux_out,
	input wire [2:0] o_cmp_ge
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	wire lg = (i_mode == 2'h0) && !i_local_set_reset[0];
	wire [1:0] opa = {i_lut_in[4], i_lut_in[0]};
	wire [1:0] opb = {i_lut_in[5], i_lut_in[1]};
	five_mux_a: assert property (i_mode == 2'h0 |-> o_five_input_mux_out[0] ==
		(i_multi_purpose_in[0] ? o_table1_comb_out[0] : o_table0_comb_out[0])) else $error("mux");
	ce_hold_a: assert property (lg && !i_clk_en[0] |=> $stable(o_reg0_out[0])) else $error("hold");
	ce_load_a: assert property (lg && i_clk_en[0] |=> o_reg0_out[0] == $past(o_table0_comb_out[0]))
		else $error("load");
	lsr_force_a: assert property (i_local_set_reset[0] |=>
		{o_reg1_out[0], o_reg0_out[0]} == {2{$past(i_set_reset_level[0])}}) else $error("set reset");
	reset_clear_a: assert property (disable iff (1'b0) i_rst |=> o_reg0_out == 3'h0) else $error("rst");
	cmp_idle_a: assert property (i_mode != 2'h1 |-> o_cmp_ge == 3'h0) else $error("cmp idle");
	cmp_ge_a: assert property (i_mode == 2'h1 && i_ripple_func == 3'h0 |-> o_cmp_ge[0] == (opa >= opb))
		else $error("ge");
	rom_fixed_a: assert property (i_mode == 2'h3 ##1 (i_mode == 2'h3 && $stable(i_lut_in))
		|-> $stable(o_table0_comb_out)) else $error("rom");
	cover property (i_mode == 2'h2 && i_local_set_reset[2]);
	cover property (i_mode == 2'h1 && i_ripple_func == 3'h6);
	cover property (i_mode == 2'h3 ##1 i_mode == 2'h3);
endmodule
bind logic_slice_lut_carry_ram logic_slice_props props (.*);

/* bench/logic_slice_lut_carry_ram_tb.sv */
`timescale 1ns/1ps
`include "logic_slice_defines.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module logic_slice_lut_carry_ram_tb;
	reg clk = 0, rst = 1, cin_q = 0, addsub = 1, sub;
	reg [1:0] mode = 0, casc_q = 0;
	reg [2:0] fn = 0, ce = 0, sr = 0, lset = 0;
	reg [95:0] init = 96'hA5C3_3C5A_0FF0_6996_1234_FEDC;
	reg [23:0] lin = 0;
	reg [5:0] mpi = 0, a, b;
	reg [6:0] e7;
	wire cin, cout;
	wire [1:0] casc;
	wire [2:0] t0, t1, r0, r1, m5, mw, ge, ne, le;
	wire [5:0] sum = {t1[2], t0[2], t1[1], t0[1], t1[0], t0[0]};
	wire [5:0] cnt = {r1[2], r0[2], r1[1], r0[1], r1[0], r0[0]};
	integer fail_count = 0, total_checks = 0, i, s;
	always #2.5 clk = ~clk;
	far_fabric nb (.i_mclk(clk), .i_carry_req(cin_q), .i_casc_req(casc_q), .o_carry(cin),
		.o_casc(casc));
	logic_slice_lut_carry_ram dut (.i_mclk(clk), .i_rst(rst), .i_mode(mode), .i_ripple_func(fn),
		.i_addsub_ctrl(addsub), .i_table_init(init), .i_lut_in(lin), .i_multi_purpose_in(mpi),
		.i_clk_en(ce), .i_local_set_reset(sr), .i_set_reset_level(lset), .i_wide_cascade_in(casc),
		.i_carry_chain_in(cin), .o_table0_comb_out(t0), .o_table1_comb_out(t1), .o_reg0_out(r0),
		.o_reg1_out(r1), .o_five_input_mux_out(m5), .o_wide_mux_out(mw),
		.o_carry_chain_out(cout), .o_cmp_ge(ge), .o_cmp_ne(ne), .o_cmp_le(le));
	task step(input integer n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		#20000;
		fail_count++;
		tally_and_finish;
	end
	initial begin
		step(3);
		rst = 0;
		for (i = 0; i < 16; i++) begin
			lin = {6{i[3:0]}};
			mpi = {3{1'b0, i[0]}};
			step(1);
			for (s = 0; s < 3; s++) begin
				`CHK(t0[s], init[32*s+i])
				`CHK(t1[s], init[32*s+16+i])
				`CHK(m5[s], init[32*s+16*i[0]+i])
			end
		end
		lin = {6{4'h5}};
		mpi = 6'h2A;
		casc_q = 2'h2;
		ce = 3'h7;
		step(2);
		`CHK(r0, {init[69], init[37], init[5]})
		`CHK(mw, {1'b0, init[37], 1'b1})
		ce = 0;
		lin = 0;
		step(1);
		`CHK(r0, {init[69], init[37], init[5]})
		sr = 3'h7;
		lset = 3'h5;
		step(1);
		`CHK({r1, r0}, 6'h2D)
		sr = 0;
		mode = `MODE_RIPPLE;
		for (i = 0; i < 12; i++) begin
			fn = 3'(i / 4);
			sub = (fn == `FN_SUB) || (fn == `FN_ADDSUB && i[0]);
			addsub = !sub;
			cin_q = sub;
			a = 6'(i * 23);
			b = 6'(63 - i * 11);
			lin = 0;
			for (s = 0; s < 3; s++)
				{lin[s*8+5], lin[s*8+4], lin[s*8+1], lin[s*8]} = {b[2*s+1], a[2*s+1], b[2*s], a[2*s]};
			step(2);
			e7 = sub ? {1'b0, a} + {1'b0, ~b} + 7'h01 : {1'b0, a} + {1'b0, b};
			`CHK({cout, sum}, e7)
			for (s = 0; s < 3; s++) begin
				`CHK({ge[s], ne[s], le[s]}, {a[2*s+:2] >= b[2*s+:2], a[2*s+:2] != b[2*s+:2],
					a[2*s+:2] <= b[2*s+:2]})
			end
		end
		lin = 0;
		fn = `FN_UPDN_CLEAR;
		cin_q = 1;
		sr = 3'h7;
		lset = 0;
		step(1);
		`CHK(cnt, 6'h00)
		sr = 0;
		ce = 3'h7;
		fn = `FN_UP_COUNT;
		step(5);
		`CHK(cnt, 6'h05)
		fn = `FN_DOWN_COUNT;
		cin_q = 0;
		// the neighbour's carry lags a cycle, so the first down edge still adds one back
		step(3);
		`CHK(cnt, 6'h03)
		fn = `FN_UPDN_LOAD;
		addsub = 1;
		cin_q = 1;
		lin = 24'hC48C04;
		step(1);
		`CHK(cnt, 6'h2C)
		mode = `MODE_RAM;
		ce = 0;
		for (i = 0; i < 16; i++) begin
			lin = {i[3:0] ^ 4'hA, i[3:0], 16'h0000};
			sr = 3'h4;
			step(1);
		end
		sr = 0;
		mode = `MODE_ROM;
		lin = 24'h030000;
		sr = 3'h4;
		step(1);
		sr = 0;
		for (i = 0; i < 16; i++) begin
			lin = {8'h00, {4{i[3:0]}}};
			step(1);
			`CHK({t1[1], t0[1], t1[0], t0[0]}, i[3:0] ^ 4'hA)
		end
		tally_and_finish;
	end
endmodule
